// file: cprc_checker.sv
// Port assertions for the power and reset control block.
// Assumes one clock and synchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module cprc_checker (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Watched ports
    input wire reset_pin_n,
    input wire sleep_pin,
    input wire pll_locked_pin,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire pll_enable,
    input wire bias_enable,
    input wire calib_active,
    input wire [7:0] channel_enable,
    input wire sample_tick,
    input wire serializer_tick,
    input wire decimate_tick,
    input wire data_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pd; reg_write && reg_addr == 4'h0 && reg_wdata[0] |-> ##2 !data_valid; endproperty
    a_pd: assert property (p_pd) else $error("valid after power-down write");
    property p_pin; !reset_pin_n |-> ##[1:4] !data_valid; endproperty
    a_pin: assert property (p_pin) else $error("valid during reset pin");
    property p_slp; sleep_pin [*8] |-> channel_enable == 8'h00 && !data_valid; endproperty
    a_slp: assert property (p_slp) else $error("channels on in sleep");
    property p_run; data_valid |-> pll_enable && bias_enable && !calib_active; endproperty
    a_run: assert property (p_run) else $error("valid without clocks");
    property p_lock; $rose(data_valid) |-> $past(pll_locked_pin, 2); endproperty
    a_lock: assert property (p_lock) else $error("valid before lock");
    property p_rd; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
    property p_ser; serializer_tick |=> !serializer_tick [*2]; endproperty
    a_ser: assert property (p_ser) else $error("serializer strobe spacing");
    property p_smp; sample_tick |-> pll_enable ##1 !sample_tick; endproperty
    a_smp: assert property (p_smp) else $error("sample strobe spacing");
    property p_dec; decimate_tick |-> sample_tick; endproperty
    a_dec: assert property (p_dec) else $error("decimation off sample clock");
    c_run: cover property ($rose(data_valid));
    c_slp: cover property (sleep_pin && data_valid);
    c_pd: cover property ($fell(pll_enable));
endmodule
bind cprc_top cprc_checker cprc_checker_inst (.clk, .rst_n, .reset_pin_n, .sleep_pin,
    .pll_locked_pin, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pll_enable,
    .bias_enable, .calib_active, .channel_enable, .sample_tick, .serializer_tick,
    .decimate_tick, .data_valid);
`default_nettype wire

// file: cprc_defs.vh
// Constants for the converter power and reset control block.
// Assumes one 100 MHz clock and a strobed register port one word wide.
// How it works
// [RQ1] Sample and serializer clock enables come from the reference clock divider.
// [RQ2] Decimation strobe follows sample clock, so filter timing scales with it.
// [RQ3] Equalizer enable bit gates the equalizer power output.
// [RQ4] Output standard and common-mode bits are written by software.
// [RQ5] Full power-down bit turns off clock generator, reference, bias, everything.
// [RQ6] Sleep pin or sleep bit enters sleep; wake time shorter than power-down.
// [RQ7] Each channel shutdown bit turns off its modulator, filter and driver.
// [RQ8] Any of three resets starts calibration and clock relock.
// [RQ9] Resets load defaults; register writes are taken during calibration.
// [RQ10] Output data invalid in reset, until lock, then until filter latency ends.
// [RQ11] Host pulses reset pin after power-up if supply order was wrong.
// [RQ12] Host should toggle sleep pin for duty cycling, not the bit.
// [RQ13] After power-down, data invalid until relock and filter latency end.
`ifndef CPRC_DEFS_VH
`define CPRC_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define CPRC_ADDR_TOP     4'h0
`define CPRC_ADDR_CHAN    4'h1
`define CPRC_ADDR_OUTCFG  4'h2
`define CPRC_ADDR_STATUS  4'h3
// ****************************************
// Field positions
// ****************************************
`define CPRC_TOP_PD       0
`define CPRC_TOP_SLEEP    1
`define CPRC_TOP_SWRST    2
`define CPRC_TOP_EQ_EN    3
`define CPRC_OUT_SCALABLE_LOW_SWING_OUTPUT     0
`define CPRC_OUT_OCM      1
// ****************************************
// Reset values
// ****************************************
`define CPRC_TOP_RESET    8'h08
`define CPRC_CHAN_RESET   8'h00
`define CPRC_OUT_RESET    8'h02
// ****************************************
// Timing counts, in clk cycles
// ****************************************
`define CPRC_CAL_CYCLES   16'h0400
`define CPRC_LOCK_PD      16'h0800
`define CPRC_LOCK_SLEEP   16'h0040
`define CPRC_LATENCY      16'h0080
`define CPRC_SAMPLE_DIV   8'h02
`define CPRC_SER_DIV      8'h03
`endif

// file: cprc_divider.v
// Free-running divider giving a one-cycle enable strobe every div cycles.
// Assumes div is at least 1; stops while run is low.
`timescale 1ns/1ps
`default_nettype none
module cprc_divider (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire run,
    input wire [7:0] div,
    // Strobe
    output reg tick
);
    reg [7:0] count;
    always @(posedge clk) begin
        if (!rst_n || !run) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count + 8'h01 >= div) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: cprc_host_model.sv
// Host pins and clock generator lock seen by the control block.
// Assumes bench commands arrive as levels synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cprc_host_model (
    // Clock and commands
    input wire logic clk,
    input wire logic cmd_rst,
    input wire logic cmd_sleep,
    input wire logic pll_enable,
    // Pins
    output logic reset_pin_n = 1'b1,
    output logic sleep_pin = 1'b0,
    output logic pll_locked_pin = 1'b0
);
    logic [7:0] rst_cnt = 8'h00;
    logic [7:0] lock_cnt = 8'h00;
    always @(posedge clk) begin
        rst_cnt <= cmd_rst ? 8'h08 : rst_cnt - {7'h00, rst_cnt != 8'h00};
        reset_pin_n <= !cmd_rst && rst_cnt == 8'h00;
        sleep_pin <= cmd_sleep;
        // Lock drops at once when disabled, so relock is always waited for
        lock_cnt <= pll_enable ? lock_cnt + {7'h00, lock_cnt != 8'h64} : 8'h00;
        pll_locked_pin <= lock_cnt == 8'h64;
    end
endmodule
`default_nettype wire

// file: cprc_sync.v
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin level is held far longer than two clk cycles.
`timescale 1ns/1ps
`default_nettype none
module cprc_sync (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pin and synchronised level
    input wire din,
    output reg dout
);
    reg stage1;
    always @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: cprc_top.v
// Reset, start-up and power mode control of an eight-channel converter.
// Assumes reset and sleep pins are asynchronous; lock indication is a pin.
`timescale 1ns/1ps
`default_nettype none
`include "cprc_defs.vh"
module cprc_top (
    // Clock and power-on reset
    input wire clk,
    input wire rst_n,
    // Pins from the host
    input wire reset_pin_n,
    input wire sleep_pin,
    // Clock generator lock from the analog side
    input wire pll_locked_pin,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Power controls to the analog side
    output reg pll_enable,
    output reg bias_enable,
    output reg calib_active,
    output reg equalizer_enable,
    output reg scalable_low_swing_output,
    output reg output_cm_high,
    output reg [7:0] channel_enable,
    // Clock strobes
    output wire sample_tick,
    output wire serializer_tick,
    output wire decimate_tick,
    // Data validity
    output reg data_valid
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_RESET = 3'h0;
    localparam ST_CAL = 3'h1;
    localparam ST_LOCK = 3'h2;
    localparam ST_LATENCY = 3'h3;
    localparam ST_RUN = 3'h4;
    localparam ST_SLEEP = 3'h5;
    localparam ST_PDOWN = 3'h6;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire rst_pin_low;
    wire sleep_req_pin;
    wire locked_sync;
    cprc_sync u_sync_rst (
        .clk(clk),
        .rst_n(rst_n),
        .din(~reset_pin_n),
        .dout(rst_pin_low)
    );
    cprc_sync u_sync_sleep (
        .clk(clk),
        .rst_n(rst_n),
        .din(sleep_pin),
        .dout(sleep_req_pin)
    );
    cprc_sync u_sync_lock (
        .clk(clk),
        .rst_n(rst_n),
        .din(pll_locked_pin),
        .dout(locked_sync)
    );

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] top_ctrl;
    reg [7:0] chan_pd;
    reg [7:0] out_cfg;
    reg sw_reset;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [15:0] count;
    reg [15:0] lock_wait;
    wire any_reset;
    wire pd_bit;
    wire sleep_req;

    assign pd_bit = top_ctrl[`CPRC_TOP_PD];
    assign sleep_req = sleep_req_pin | top_ctrl[`CPRC_TOP_SLEEP]; // RQ6
    // Three reset sources meet here
    assign any_reset = !rst_n | rst_pin_low | sw_reset; // RQ8

    // Writes taken in every state, even during calibration
    always @(posedge clk) begin
        if (any_reset) begin
            top_ctrl <= `CPRC_TOP_RESET; // RQ9
            chan_pd <= `CPRC_CHAN_RESET;
            out_cfg <= `CPRC_OUT_RESET;
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= 1'b0;
            if (reg_write) begin
                case (reg_addr)
                    `CPRC_ADDR_TOP: begin
                        top_ctrl <= reg_wdata & 8'hFB; // RQ9
                        sw_reset <= reg_wdata[`CPRC_TOP_SWRST]; // RQ8
                    end
                    `CPRC_ADDR_CHAN: chan_pd <= reg_wdata; // RQ7
                    `CPRC_ADDR_OUTCFG: out_cfg <= reg_wdata & 8'h03; // RQ4
                    default: ;
                endcase
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `CPRC_ADDR_TOP: reg_rdata <= top_ctrl;
                `CPRC_ADDR_CHAN: reg_rdata <= chan_pd;
                `CPRC_ADDR_OUTCFG: reg_rdata <= out_cfg;
                `CPRC_ADDR_STATUS: reg_rdata <= {3'h0, locked_sync, data_valid, state};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: next_state = ST_CAL; // RQ8
            ST_CAL: if (count == `CPRC_CAL_CYCLES) next_state = ST_LOCK;
            ST_LOCK: if (locked_sync && count >= lock_wait) next_state = ST_LATENCY; // RQ10
            ST_LATENCY: if (count == `CPRC_LATENCY) next_state = ST_RUN; // RQ10
            ST_RUN: begin
                if (pd_bit) next_state = ST_PDOWN; // RQ5
                else if (sleep_req) next_state = ST_SLEEP; // RQ6
            end
            ST_SLEEP: begin
                if (pd_bit) next_state = ST_PDOWN;
                else if (!sleep_req) next_state = ST_LOCK;
            end
            // Relock and latency again, as after reset but without calibration
            ST_PDOWN: if (!pd_bit) next_state = ST_LOCK; // RQ13
            default: next_state = ST_RESET;
        endcase
    end

    always @(posedge clk) begin
        if (any_reset) begin
            state <= ST_RESET;
            count <= 16'h0000;
            lock_wait <= `CPRC_LOCK_PD;
        end else begin
            state <= next_state;
            if (next_state != state) count <= 16'h0000;
            else if (count != 16'hFFFF) count <= count + 16'h0001;
            // Sleep keeps the bias up, so the wake wait is shorter
            if (state == ST_SLEEP && next_state == ST_LOCK) lock_wait <= `CPRC_LOCK_SLEEP; // RQ6
            else if (state == ST_PDOWN) lock_wait <= `CPRC_LOCK_PD; // RQ5
        end
    end

    // ****************************************
    // Power outputs
    // ****************************************
    always @(posedge clk) begin
        if (any_reset) begin
            pll_enable <= 1'b0;
            bias_enable <= 1'b0;
            calib_active <= 1'b0;
            equalizer_enable <= 1'b0;
            scalable_low_swing_output <= 1'b0;
            output_cm_high <= 1'b0;
            channel_enable <= 8'h00;
            data_valid <= 1'b0; // RQ10
        end else begin
            pll_enable <= (next_state != ST_PDOWN); // RQ5
            bias_enable <= (next_state != ST_PDOWN); // RQ5
            calib_active <= (next_state == ST_CAL); // RQ8
            // Equalizer unpowered when disabled
            equalizer_enable <= top_ctrl[`CPRC_TOP_EQ_EN] && next_state == ST_RUN; // RQ3
            scalable_low_swing_output <= out_cfg[`CPRC_OUT_SCALABLE_LOW_SWING_OUTPUT]; // RQ4
            output_cm_high <= out_cfg[`CPRC_OUT_OCM]; // RQ4
            // Sleep and power-down take every channel down
            channel_enable <= (next_state == ST_SLEEP || next_state == ST_PDOWN)
                ? 8'h00 : ~chan_pd; // RQ7
            data_valid <= (next_state == ST_RUN); // RQ10
        end
    end

    // ****************************************
    // Clock strobes
    // ****************************************
    wire clocks_run;
    // Follows the next value of pll_enable, so no strobe outlives the clock generator
    assign clocks_run = !any_reset && (next_state != ST_PDOWN) && locked_sync; // RQ5
    cprc_divider u_div_sample (
        .clk(clk),
        .rst_n(rst_n),
        .run(clocks_run),
        .div(`CPRC_SAMPLE_DIV),
        .tick(sample_tick)
    ); // RQ1
    cprc_divider u_div_ser (
        .clk(clk),
        .rst_n(rst_n),
        .run(clocks_run),
        .div(`CPRC_SER_DIV),
        .tick(serializer_tick)
    ); // RQ1
    // Decimation follows the sample strobe, so filter rate scales with it
    assign decimate_tick = sample_tick & (state == ST_RUN || state == ST_LATENCY); // RQ2
endmodule
`default_nettype wire

// file: cprc_top_test.sv
// Self-checking bench for the power and reset control block.
// Assumes the host model stands in for pins and lock.
`timescale 1ns/1ps
`default_nettype none
module cprc_top_test;
    logic clk = 1'b0, rst_n = 1'b0, cmd_rst = 1'b0, cmd_sleep = 1'b0, rd_d = 1'b0;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, cm;
    logic [7:0] exp_q[$];
    wire reset_pin_n, sleep_pin, pll_locked_pin, pll_enable, bias_enable, calib_active;
    wire equalizer_enable, scalable_low_swing_output, output_cm_high, sample_tick;
    wire serializer_tick, decimate_tick, data_valid;
    wire [7:0] reg_rdata, channel_enable;
    int err_total = 0, cmp_count = 0, ns, np, n1, n2, n3;
    initial begin forever #5 clk = ~clk; end
    cprc_top cprc_top_inst (.clk, .rst_n, .reset_pin_n, .sleep_pin, .pll_locked_pin, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pll_enable, .bias_enable, .calib_active,
        .equalizer_enable, .scalable_low_swing_output, .output_cm_high, .channel_enable,
        .sample_tick, .serializer_tick, .decimate_tick, .data_valid);
    cprc_host_model cprc_host_model_inst (.clk, .cmd_rst, .cmd_sleep, .pll_enable,
        .reset_pin_n, .sleep_pin, .pll_locked_pin);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        {reg_read, reg_addr} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask
    task automatic wv(output int n);
        n = 0;
        while (data_valid !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9000) chk("wake", 8'h01, 8'h00);
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_d <= reg_read;
    always @(negedge clk) begin
        if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(2));
        cm = 8'($urandom);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h0, 8'h08);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h02);
        rd(4'hF, 8'h00);
        wr(4'h1, cm);
        rd(4'h1, cm);
        settle;
        chk("calib", 8'h01, {7'h00, calib_active});
        wv(n1);
        settle;
        chk("chan", ~cm, channel_enable);
        rd(4'h3, 8'h1C);
        chk("eq", 8'h01, {7'h00, equalizer_enable});
        {n1, n2, n3} = '0;
        repeat (30) begin
            @(negedge clk);
            {n1, n2, n3} = {n1 + sample_tick, n2 + serializer_tick, n3 + decimate_tick};
        end
        chk("ticks", 8'h0F, 8'(n1));
        chk("ser", 8'h0A, 8'(n2));
        chk("dec", 8'h0F, 8'(n3));
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h01);
        settle;
        chk("eq", 8'h00, {7'h00, equalizer_enable});
        chk("out", 8'h01, {6'h00, output_cm_high, scalable_low_swing_output});
        @(posedge clk);
        cmd_sleep <= 1'b1;
        settle;
        chk("slp", 8'h00, {channel_enable[7:1], channel_enable[0] | data_valid});
        @(posedge clk);
        cmd_sleep <= 1'b0;
        wv(ns);
        wr(4'h0, 8'h02);
        settle;
        chk("slpbit", 8'h00, {7'h00, data_valid});
        wr(4'h0, 8'h00);
        wv(n1);
        wr(4'h0, 8'h01);
        settle;
        chk("pd", 8'h00, {6'h00, pll_enable, bias_enable});
        wr(4'h0, 8'h00);
        wv(np);
        chk("wake", 8'h01, {7'h00, ns < np});
        wr(4'h0, 8'h04);
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h08);
        wv(n1);
        wr(4'h1, cm);
        @(posedge clk);
        cmd_rst <= 1'b1;
        @(posedge clk);
        cmd_rst <= 1'b0;
        settle;
        chk("pin", 8'h00, {7'h00, data_valid});
        settle;
        rd(4'h1, 8'h00);
        settle;
        complete_run;
    end
    initial begin
        #800000;
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
